// File: design/roc_relay.sv
// Purpose: conditions one relay output from a status source or a word bit
// Assumes: status inputs and error flag come from logic on i_sys_clk
// Notes: registers on a plain strobe port, read data one cycle later
//
// What this block does
// - The relay follows one selectable status, fault-free status by default.
// - Unassigned, the relay follows a word bit and holds on error by default.
// - Activation waits an on-delay of 0 to 60000 ms, default 0, after true.
// - With fault-free source the on-delay is treated as zero.
// - High polarity drives 1 while true, low drives 0; high is default.
// - With fault-free source polarity is forced high and writes rejected.
// - Release waits a hold of 0 to 9999 ms, default 0, after false.
// - With fault-free source the hold time is treated as zero.
// - With fallback on, the word bit drives the relay, forced off on error.
// - Fallback reads disabled whenever a source is assigned; default off.
// - On error the delay, hold and polarity processing stays applied.
// - With fallback off the relay follows its source and holds on error, except with fault-free source.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module roc_relay #(
    parameter int N_SRC = 63 // number of status sources besides none
) (
    input wire logic i_sys_clk, // system clock
    input wire logic i_reset_n, // synchronous reset, active low
    input wire logic [62:0] i_status, // status bit k is source code k+1
    input wire logic i_error, // error detected, incl. comm loss
    input wire roc_pkg::roc_bus_req_t i_bus, // register request
    output logic [31:0] o_rdata, // read data, cycle after strobe
    output logic o_relay // relay coil drive
);
    // refuse a source count that the status bus cannot serve
    if (N_SRC < 1 || N_SRC > 63) begin : g_bad_n_src
        $error("N_SRC out of range");
    end

    logic [5:0] src_ff;
    logic [15:0] on_delay_ff;
    logic [15:0] hold_ff;
    logic pol_low_ff;
    logic fallback_ff;
    logic [3:0] wbit_ff;
    logic [15:0] word_ff;
    logic [16:0] pre_ff;
    logic ms_tick_ff;
    logic [15:0] tmr_ff;
    logic state_ff;
    logic err_ff;
    logic relay_ff;
    logic [31:0] rdata_ff;
    logic ff_src;
    logic src_val;
    logic eff_fb;
    logic cur_in;
    logic wr_src, wr_on, wr_hold, wr_ctrl, wr_word;
    logic src_wr_ok;

    assign ff_src = (src_ff == roc_pkg::SRC_FAULT_FREE);
    // fallback only exists while unassigned
    assign eff_fb = fallback_ff && (src_ff == roc_pkg::SRC_NONE);

    // register write decode
    assign wr_src = i_bus.wr && i_bus.addr == roc_pkg::ADDR_SRC;
    assign wr_on = i_bus.wr && i_bus.addr == roc_pkg::ADDR_ON_DELAY;
    assign wr_hold = i_bus.wr && i_bus.addr == roc_pkg::ADDR_HOLD;
    assign wr_ctrl = i_bus.wr && i_bus.addr == roc_pkg::ADDR_CTRL;
    assign wr_word = i_bus.wr && i_bus.addr == roc_pkg::ADDR_WORD;

    // a source write past the last status code is refused whole, so
    // stray upper bits cannot alias onto a valid code
    assign src_wr_ok = wr_src && i_bus.wdata <= 32'(N_SRC);

    // source selection register
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            src_ff <= roc_pkg::SRC_RST;
        end else if (src_wr_ok) begin
            src_ff <= i_bus.wdata[5:0];
        end
    end

    // delay and hold registers, out-of-range writes clamp to limit
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            on_delay_ff <= roc_pkg::TIME_RST;
            hold_ff <= roc_pkg::TIME_RST;
        end else begin
            if (wr_on) begin
                on_delay_ff <= (i_bus.wdata > 32'(roc_pkg::ON_DELAY_MAX_MS))
                    ? 16'(roc_pkg::ON_DELAY_MAX_MS) : i_bus.wdata[15:0];
            end
            if (wr_hold) begin
                hold_ff <= (i_bus.wdata > 32'(roc_pkg::HOLD_MAX_MS))
                    ? 16'(roc_pkg::HOLD_MAX_MS) : i_bus.wdata[15:0];
            end
        end
    end

    // control register: polarity, fallback, word bit index
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            pol_low_ff <= 1'b0;
            fallback_ff <= 1'b0;
            wbit_ff <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                fallback_ff <= i_bus.wdata[roc_pkg::CTRL_FALLBACK_BIT];
                wbit_ff <= i_bus.wdata[roc_pkg::CTRL_WBIT_LSB +: 4];
            end
            // a fault-free selection clears low polarity in the same edge
            if (ff_src || (src_wr_ok && i_bus.wdata[5:0] ==
                           roc_pkg::SRC_FAULT_FREE)) begin
                pol_low_ff <= 1'b0;
            end else if (wr_ctrl) begin
                pol_low_ff <= i_bus.wdata[roc_pkg::CTRL_POL_LOW_BIT];
            end
        end
    end

    // remote logic output word
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            word_ff <= roc_pkg::WORD_RST;
        end else if (wr_word) begin
            word_ff <= i_bus.wdata[15:0];
        end
    end

    // read data, valid only the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                roc_pkg::ADDR_SRC: rdata_ff <= {26'h0, src_ff};
                roc_pkg::ADDR_ON_DELAY: rdata_ff <= {16'h0, on_delay_ff};
                roc_pkg::ADDR_HOLD: rdata_ff <= {16'h0, hold_ff};
                roc_pkg::ADDR_CTRL: rdata_ff <= {24'h0, wbit_ff, 2'b00,
                                                 eff_fb, pol_low_ff};
                roc_pkg::ADDR_WORD: rdata_ff <= {16'h0, word_ff};
                roc_pkg::ADDR_STAT: rdata_ff <= {29'h0, err_ff, state_ff,
                                                 relay_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    // millisecond timebase, free running: the first tick after a change
    // may come at any point, so each wait is D-1 to D ms long
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            pre_ff <= 17'h0_0000;
            ms_tick_ff <= 1'b0;
        end else if (pre_ff == 17'(roc_pkg::CYC_PER_MS - 1)) begin
            pre_ff <= 17'h0_0000;
            ms_tick_ff <= 1'b1;
        end else begin
            pre_ff <= pre_ff + 17'h0_0001;
            ms_tick_ff <= 1'b0;
        end
    end

    // raw source: assigned status or word bit
    always_comb begin
        if (src_ff == roc_pkg::SRC_NONE) begin
            src_val = word_ff[wbit_ff];
        end else begin
            src_val = i_status[src_ff - 6'h01];
        end
    end

    // error: fallback forces off, else hold the current state unless fault-free
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= i_error;
        end
    end

    // fault-free source already reflects the error itself
    always_comb begin
        if (eff_fb && i_error) begin
            cur_in = 1'b0;
        end else if (i_error && !ff_src) begin
            cur_in = state_ff;
        end else begin
            cur_in = src_val;
        end
    end

    // on-delay and hold timer, processing kept during error
    // the timer clears as the state switches once it reaches its limit, so it cannot wrap
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state_ff <= 1'b0;
            tmr_ff <= 16'h0000;
        end else if (cur_in == state_ff) begin
            tmr_ff <= 16'h0000; // revert keeps state, timer restarts
        end else if (ff_src) begin
            state_ff <= cur_in;
            tmr_ff <= 16'h0000;
        end else if (cur_in && tmr_ff >= on_delay_ff) begin
            state_ff <= 1'b1;
            tmr_ff <= 16'h0000;
        end else if (!cur_in && tmr_ff >= hold_ff) begin
            state_ff <= 1'b0;
            tmr_ff <= 16'h0000;
        end else if (ms_tick_ff) begin
            tmr_ff <= tmr_ff + 16'h0001;
        end
    end

    // polarity applied last
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            relay_ff <= 1'b0;
        end else begin
            relay_ff <= state_ff ^ pol_low_ff;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_relay = relay_ff;

    // named sequences for the fallback path
    sequence s_fb_err;
        eff_fb && i_error && hold_ff == 16'h0000;
    endsequence
    sequence s_fb_off;
        !state_ff ##1 relay_ff == $past(pol_low_ff);
    endsequence

    // fallback with no hold: state drops, relay shows the off level
    a_fallback_forces_off: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) s_fb_err |=> s_fb_off)
        else $error("fallback did not clear relay");

    // fallback with an error never switches the state on
    a_fb_no_rise: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) eff_fb && i_error && !state_ff
        |=> !state_ff)
        else $error("state rose under fallback error");

    // fallback reads back off while a source is assigned
    a_fb_forced_off: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) i_bus.rd
        && i_bus.addr == roc_pkg::ADDR_CTRL && src_ff != roc_pkg::SRC_NONE
        |=> !o_rdata[roc_pkg::CTRL_FALLBACK_BIT])
        else $error("fallback active while assigned");

    // a fault-free selection never leaves low polarity standing
    a_pol_forced_high: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) ff_src |-> !pol_low_ff)
        else $error("polarity not high for fault-free source");

    // fault-free source passes straight through, no delay
    a_ff_no_delay: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) ff_src && $stable(src_ff) && !i_error
        && src_val != state_ff |=> state_ff == $past(src_val))
        else $error("fault-free source delayed");

    // without fallback or fault-free source an error freezes the state
    a_hold_on_error: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) i_error && !eff_fb && !ff_src
        && $stable(src_ff) && $past(i_error) |=> $stable(state_ff))
        else $error("state moved during error without fallback");

    // polarity is applied one cycle after the state
    a_polarity_map: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) ##1 relay_ff == ($past(state_ff)
        ^ $past(pol_low_ff)))
        else $error("relay polarity wrong");

    // no activation before the on-delay has run out
    a_on_delay_wait: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) $rose(state_ff) && !$past(ff_src)
        |-> $past(tmr_ff) >= $past(on_delay_ff))
        else $error("relay activated before on-delay");

    // no release before the hold time has run out
    a_hold_wait: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) $fell(state_ff) && !$past(ff_src)
        |-> $past(tmr_ff) >= $past(hold_ff))
        else $error("relay released before hold time");

    // a reverted input clears the timer
    a_timer_restart: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) cur_in == state_ff |=> tmr_ff == 16'h0000)
        else $error("timer not restarted on revert");

    // a source write past the last status code is ignored
    a_src_refused: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) wr_src && i_bus.wdata > 32'(N_SRC)
        |=> $stable(src_ff))
        else $error("out-of-range source write accepted");

    // programmed times never exceed their limits
    a_delay_limit: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        on_delay_ff <= 16'(roc_pkg::ON_DELAY_MAX_MS))
        else $error("on-delay above limit");
    a_hold_limit: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) hold_ff <= 16'(roc_pkg::HOLD_MAX_MS))
        else $error("hold time above limit");

    // a pending change whose timer has run out
    sequence s_on_due;
        cur_in && !state_ff && !ff_src && tmr_ff >= on_delay_ff;
    endsequence
    sequence s_hold_due;
        !cur_in && state_ff && !ff_src && tmr_ff >= hold_ff;
    endsequence

    // once the on-delay has run out the state switches on
    a_on_delay_fires: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) s_on_due |=> state_ff)
        else $error("relay not activated after on-delay");

    // once the hold time has run out the state switches off
    a_hold_fires: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) s_hold_due |=> !state_ff)
        else $error("relay not released after hold time");

    // the timer never runs past the longest programmable time
    a_tmr_no_overrun: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        tmr_ff <= 16'(roc_pkg::ON_DELAY_MAX_MS))
        else $error("timer ran past the longest time");

    // with no source and zero times the state tracks the word bit
    a_word_follow: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) src_ff == roc_pkg::SRC_NONE && !i_error
        && on_delay_ff == 16'h0000 && hold_ff == 16'h0000
        |=> state_ff == $past(src_val))
        else $error("state does not follow the word bit");

    // read data stands only in the cycle after a read strobe
    a_rdata_idle: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n) !i_bus.rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    // the relay sits at its inactive level out of reset
    a_relay_in_reset: assert property (@(posedge i_sys_clk)
        !i_reset_n |=> !relay_ff)
        else $error("relay not released by reset");
endmodule : roc_relay

// File: pkg/roc_pkg.sv
// Purpose: constants and types for the relay output conditioner
// Assumes: 125 MHz system clock, millisecond timebase derived here
// Notes: source code 0 means unassigned
package roc_pkg;
    // clock and millisecond timebase
    localparam int CLK_HZ = 125_000_000;
    localparam int MS_UNIT = 1;
    localparam int CYC_PER_MS = CLK_HZ / 1000 * MS_UNIT;
    localparam int PRE_W = 17;
    // delay limits in milliseconds
    localparam int ON_DELAY_MAX_MS = 60000;
    localparam int HOLD_MAX_MS = 9999;
    localparam int TIME_W = 16;
    // register offsets
    localparam logic [3:0] ADDR_SRC = 4'h0;
    localparam logic [3:0] ADDR_ON_DELAY = 4'h1;
    localparam logic [3:0] ADDR_HOLD = 4'h2;
    localparam logic [3:0] ADDR_CTRL = 4'h3;
    localparam logic [3:0] ADDR_WORD = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h5;
    // field positions in control register
    localparam int CTRL_POL_LOW_BIT = 0;
    localparam int CTRL_FALLBACK_BIT = 1;
    localparam int CTRL_WBIT_LSB = 4;
    // source codes and reset values
    localparam int SRC_W = 6;
    localparam logic [5:0] SRC_NONE = 6'h00;
    localparam logic [5:0] SRC_FAULT_FREE = 6'h01;
    localparam logic [5:0] SRC_RST = SRC_FAULT_FREE;
    localparam logic [15:0] TIME_RST = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } roc_bus_req_t;
endpackage : roc_pkg

// File: tb/roc_coil_model.sv
// Purpose: relay coil and contact driven by the conditioner output
// Assumes: contact follows the coil one clock later
// Notes: no contact bounce is modelled
`timescale 1ns/10ps
module roc_coil_model (
    input wire logic i_sys_clk, // system clock
    input wire logic i_drive, // coil drive from the block
    output logic o_closed // contact state
);
    // contact closes or opens one cycle after the coil drive changes
    always_ff @(posedge i_sys_clk) begin
        o_closed <= i_drive;
    end
endmodule : roc_coil_model

// File: tb/roc_relay_test.sv
// Purpose: self-checking bench for the relay output conditioner
// Assumes: delays above zero are only checked for not firing early
// Notes: one task per scenario, registers reached over the strobe port
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; \
    if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module roc_relay_test;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [62:0] status = '0;
    logic err = 1'b0;
    roc_pkg::roc_bus_req_t bus = '0;
    logic [31:0] rdata;
    logic relay;
    logic closed;
    int failures = 0;
    int checks_done = 0;
    // clock at 125 MHz
    always #4 i_sys_clk = ~i_sys_clk;
    roc_relay roc_relay_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_status(status), .i_error(err), .i_bus(bus), .o_rdata(rdata),
        .o_relay(relay));
    roc_coil_model roc_coil_model_inst (.i_sys_clk(i_sys_clk),
        .i_drive(relay), .o_closed(closed));
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_sys_clk);
        bus.wr <= 1'b0;
    endtask : wr_reg
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge i_sys_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic chk_reg(input string nm, input logic [3:0] a,
        input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        `CHK(nm, e, d)
    endtask : chk_reg
    // bounded wait for the relay to reach a level
    task automatic wait_relay(input string nm, input logic e);
        int n;
        n = 0;
        #1;
        while (relay !== e && n < 8) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        `CHK(nm, e, relay)
    endtask : wait_relay
    // relay must sit at the level after a stretch of 200 cycles
    task automatic hold_relay(input string nm, input logic e);
        repeat (200) @(posedge i_sys_clk);
        #1;
        `CHK(nm, e, relay)
    endtask : hold_relay
    task automatic set_st(input int k, input logic v);
        @(posedge i_sys_clk);
        status[k] <= v;
    endtask : set_st
    task automatic set_err(input logic v);
        @(posedge i_sys_clk);
        err <= v;
    endtask : set_err
    task automatic t_defaults();
        chk_reg("source", roc_pkg::ADDR_SRC, 32'h0000_0001);
        chk_reg("on_delay", roc_pkg::ADDR_ON_DELAY, 32'h0000_0000);
        chk_reg("hold", roc_pkg::ADDR_HOLD, 32'h0000_0000);
        chk_reg("ctrl", roc_pkg::ADDR_CTRL, 32'h0000_0000);
        chk_reg("unmapped", 4'hF, 32'h0000_0000);
    endtask : t_defaults
    // fault-free source: delays, hold and low polarity do not apply
    task automatic t_fault_free();
        wr_reg(roc_pkg::ADDR_ON_DELAY, 32'h0000_03E8);
        wr_reg(roc_pkg::ADDR_HOLD, 32'h0000_03E8);
        wr_reg(roc_pkg::ADDR_CTRL, 32'h0000_0001);
        chk_reg("ctrl_pol", roc_pkg::ADDR_CTRL, 32'h0000_0000);
        set_st(0, 1'b1);
        wait_relay("ff_on", 1'b1);
        @(posedge i_sys_clk);
        #1;
        `CHK("coil", 1'b1, closed)
        set_st(0, 1'b0);
        wait_relay("ff_off", 1'b0);
        wr_reg(roc_pkg::ADDR_ON_DELAY, 32'h0000_0000);
        wr_reg(roc_pkg::ADDR_HOLD, 32'h0000_0000);
    endtask : t_fault_free
    // unassigned source follows word bit 3 and holds on error
    task automatic t_word();
        wr_reg(roc_pkg::ADDR_SRC, 32'h0000_0000);
        wr_reg(roc_pkg::ADDR_CTRL, 32'h0000_0030);
        wr_reg(roc_pkg::ADDR_WORD, 32'h0000_0008);
        wait_relay("word_on", 1'b1);
        set_err(1'b1);
        wr_reg(roc_pkg::ADDR_WORD, 32'h0000_0000);
        hold_relay("err_keep", 1'b1);
        set_err(1'b0);
        wait_relay("word_off", 1'b0);
    endtask : t_word
    // fallback forces the output off on error, polarity still applied
    task automatic t_fallback();
        logic [31:0] d;
        wr_reg(roc_pkg::ADDR_CTRL, 32'h0000_0032);
        rd_reg(roc_pkg::ADDR_CTRL, d);
        `CHK("fb_on_read", 1'b1, d[1])
        wr_reg(roc_pkg::ADDR_WORD, 32'h0000_0008);
        wait_relay("fb_on", 1'b1);
        set_err(1'b1);
        wait_relay("fb_err_off", 1'b0);
        wr_reg(roc_pkg::ADDR_CTRL, 32'h0000_0033);
        wait_relay("fb_err_pol", 1'b1);
        chk_reg("status", roc_pkg::ADDR_STAT, 32'h0000_0005);
        set_err(1'b0);
        wait_relay("fb_clear", 1'b0);
        wr_reg(roc_pkg::ADDR_SRC, 32'h0000_0002);
        rd_reg(roc_pkg::ADDR_CTRL, d);
        `CHK("fb_forced", 1'b0, d[1])
    endtask : t_fallback
    // assigned source with low polarity, then frozen by an error
    task automatic t_polarity();
        wait_relay("low_idle", 1'b1);
        set_st(1, 1'b1);
        wait_relay("low_true", 1'b0);
        set_st(1, 1'b0);
        wait_relay("low_false", 1'b1);
        set_err(1'b1);
        set_st(1, 1'b1);
        hold_relay("src_err_keep", 1'b1);
        set_st(1, 1'b0);
        set_err(1'b0);
    endtask : t_polarity
    // on-delay holds activation; a revert keeps the relay off; clamps
    task automatic t_delay();
        wr_reg(roc_pkg::ADDR_CTRL, 32'h0000_0000);
        wait_relay("high_idle", 1'b0);
        wr_reg(roc_pkg::ADDR_ON_DELAY, 32'h0000_0001);
        set_st(1, 1'b1);
        hold_relay("delay_wait", 1'b0);
        set_st(1, 1'b0);
        hold_relay("revert_keep", 1'b0);
        wr_reg(roc_pkg::ADDR_ON_DELAY, 32'h0000_FFFF);
        chk_reg("on_clamp", roc_pkg::ADDR_ON_DELAY, 32'h0000_EA60);
        wr_reg(roc_pkg::ADDR_HOLD, 32'h0000_FFFF);
        chk_reg("hold_clamp", roc_pkg::ADDR_HOLD, 32'h0000_270F);
        wr_reg(roc_pkg::ADDR_SRC, 32'h0000_0041);
        chk_reg("src_refused", roc_pkg::ADDR_SRC, 32'h0000_0002);
    endtask : t_delay
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // watchdog far beyond the thousand or so cycles the run needs
    initial begin
        #(8 * 20000);
        failures++;
        report_and_stop();
    end
    // reset for 12 cycles, then the scenarios
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        t_defaults();
        t_fault_free();
        t_word();
        t_fallback();
        t_polarity();
        t_delay();
        report_and_stop();
    end
endmodule : roc_relay_test
